// *** core/fhc_host.sv ***
// host controller issuing reset, autoselect and query sequences to a nor flash
// assumes the flash is in array read after power-up and samples pins on core_clk
//
// Operation
// - issue only valid command sequences; reset recovers; this host passes any OP_WRITE_RAW write through unchecked
// - timeout status high: host writes reset; this host only sets timeoutSeen and leaves the caller to request OP_RESET
// - buffer abort status: send abort reset sequence; this host only sets abortSeen and leaves the caller to request OP_ABORT_RESET
// - two unlocks then autoselect command
`timescale 1ns/10ps
module fhc_host
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       clkEn,
  // user side
  input  wire logic                       reqValid,
  input  fhc_pkg::fhc_req_type            req,
  input  wire logic                       byteMode,
  output logic                            reqReady,
  output logic                            rspValid,
  output logic [fhc_pkg::DATA_W-1:0]      rspData,
  output logic                            timeoutSeen,
  output logic                            abortSeen,
  output logic                            inAutoselect,
  // flash pins
  input  wire logic [fhc_pkg::DATA_W-1:0] dqIn,
  output fhc_pkg::fhc_pins_type           flashPins
);
  import fhc_pkg::*;

  // ***************
  // sequencer
  // ***************
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN  = 2'b01,
    S_WAIT = 2'b10
  } fhc_seq_type;

  fhc_seq_type       state, next_state;
  fhc_op_type        op, next_op;
  logic [ADDR_W-1:0] uAddr, next_uAddr;
  logic [DATA_W-1:0] uData, next_uData;
  logic [1:0]        step, next_step;
  logic              modeId, next_modeId;
  logic              next_reqReady, next_rspValid, next_timeoutSeen, next_abortSeen;
  logic [DATA_W-1:0] next_rspData;

  logic              cycStart, cycWrite, cycDone;
  logic [ADDR_W-1:0] cycAddr;
  logic [DATA_W-1:0] cycData, cycRdata;

  fhc_bus_cycle uCycle
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .start    (cycStart),
    .isWrite  (cycWrite),
    .addr     (cycAddr),
    .wdata    (cycData),
    .done     (cycDone),
    .rdata    (cycRdata),
    .dqIn     (dqIn),
    .pins     (flashPins)
  );

  // number of bus cycles minus one per operation
  function automatic logic [1:0] last_step(input fhc_op_type o);
    unique case (o)
      OP_AUTOSELECT, OP_ABORT_RESET: last_step = 2'd2;
      default:                       last_step = 2'd0;
    endcase
  endfunction : last_step

  // ***************
  // bus cycle selection
  // ***************
  always_comb
  begin
    cycWrite = 1'b1;
    cycAddr  = uAddr;
    cycData  = uData;
    unique case (op)
      OP_READ, OP_ID_READ:
      begin
        // plain array read, or identifier/query word offset, doubled to a byte offset in byte mode
        cycWrite = 1'b0;
        cycAddr  = (op == OP_ID_READ) ? bus_ofs(byteMode, uAddr) : uAddr;
      end
      OP_RESET:
      begin
        cycAddr = '0;
        cycData = RESET_DATA;
      end
      OP_AUTOSELECT, OP_ABORT_RESET:
        unique case (step)
          2'd0:
          begin
            cycAddr = bus_ofs(byteMode, UNLOCK1_ADDR);
            cycData = UNLOCK1_DATA;
          end
          2'd1:
          begin
            cycAddr = bus_ofs(byteMode, UNLOCK2_ADDR);
            cycData = UNLOCK2_DATA;
          end
          default:
          begin
            cycAddr = bus_ofs(byteMode, (op == OP_ABORT_RESET) ? ABORT_RST_A3 : UNLOCK1_ADDR);
            cycData = (op == OP_ABORT_RESET) ? RESET_DATA : AUTOSEL_DATA;
          end
        endcase
      OP_QUERY:
      begin
        cycAddr = bus_ofs(byteMode, QUERY_ADDR);
        cycData = QUERY_DATA;
      end
      default:
        cycAddr = uAddr;
    endcase
  end

  assign cycStart = (state == S_RUN);

  always_comb
  begin
    next_state       = state;
    next_op          = op;
    next_uAddr       = uAddr;
    next_uData       = uData;
    next_step        = step;
    next_modeId      = modeId;
    next_reqReady    = reqReady;
    next_rspValid    = 1'b0;
    next_rspData     = rspData;
    next_timeoutSeen = timeoutSeen;
    next_abortSeen   = abortSeen;
    unique case (state)
      S_IDLE:
        if (reqValid && reqReady)
        begin
          next_op       = req.op;
          next_uAddr    = req.addr;
          next_uData    = req.data;
          next_step     = 2'd0;
          next_reqReady = 1'b0;
          next_state    = S_RUN;
        end
      S_RUN:
        next_state = S_WAIT;
      S_WAIT:
        if (cycDone)
        begin
          if (step != last_step(op))
          begin
            next_step  = step + 2'd1;
            next_state = S_RUN;
          end
          else
          begin
            if (op == OP_READ || op == OP_ID_READ)
            begin
              next_rspData = cycRdata;
              // status bits of a polled read; caller must follow with reset
              if (cycRdata[TIMEOUT_STATUS_BIT])
                next_timeoutSeen = 1'b1;
              if (cycRdata[BUFFER_ABORT_STATUS_BIT])
                next_abortSeen = 1'b1;
            end
            if (op == OP_AUTOSELECT || op == OP_QUERY)
              next_modeId = 1'b1;
            if (op == OP_RESET || op == OP_ABORT_RESET)
            begin
              // leaves autoselect/query and aborts pending sequences
              next_modeId      = 1'b0;
              next_timeoutSeen = 1'b0;
              next_abortSeen   = 1'b0;
            end
            next_rspValid = 1'b1;
            next_reqReady = 1'b1;
            next_state    = S_IDLE;
          end
        end
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state       <= S_IDLE;
      op          <= OP_READ;
      uAddr       <= '0;
      uData       <= '0;
      step        <= 2'd0;
      modeId      <= 1'b0;
      reqReady    <= 1'b1;
      rspValid    <= 1'b0;
      rspData     <= 16'h0000;
      timeoutSeen <= 1'b0;
      abortSeen   <= 1'b0;
    end
    else if (clkEn)
    begin
      state       <= next_state;
      op          <= next_op;
      uAddr       <= next_uAddr;
      uData       <= next_uData;
      step        <= next_step;
      modeId      <= next_modeId;
      reqReady    <= next_reqReady;
      rspValid    <= next_rspValid;
      rspData     <= next_rspData;
      timeoutSeen <= next_timeoutSeen;
      abortSeen   <= next_abortSeen;
    end
  end

  assign inAutoselect = modeId;

endmodule : fhc_host

// *** common/fhc_pkg.sv ***
// package for the flash command host: bus timing, command codes, query offsets
// assumes a 16-bit parallel flash on an asynchronous bus, host clock 100 MHz
package fhc_pkg;

  // ***************
  // widths
  // ***************
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;

  // ***************
  // timing
  // ***************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS     = 60;
  localparam int SETUP_NS      = 20;
  localparam int HOLD_NS       = 20;
  localparam int READ_NS       = 90;
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] READ_CYC   = 8'((READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ***************
  // command values and unlock addresses
  // ***************
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR  = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR  = 22'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA  = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA  = 16'h0055;
  localparam logic [DATA_W-1:0] AUTOSEL_DATA  = 16'h0090;
  localparam logic [DATA_W-1:0] RESET_DATA    = 16'h00f0;
  localparam logic [DATA_W-1:0] QUERY_DATA    = 16'h0098;
  localparam logic [ADDR_W-1:0] QUERY_ADDR    = 22'h000055;
  localparam logic [ADDR_W-1:0] ABORT_RST_A3  = 22'h000555;

  // ***************
  // identifier and query word offsets
  // ***************
  localparam logic [7:0] ID_MFR_OFS    = 8'h00;
  localparam logic [7:0] ID_DEV1_OFS   = 8'h01;
  localparam logic [7:0] ID_PROT_OFS   = 8'h02;
  localparam logic [7:0] ID_LOCK_OFS   = 8'h03;
  localparam logic [7:0] ID_DEV2_OFS   = 8'h0e;
  localparam logic [7:0] ID_DEV3_OFS   = 8'h0f;
  localparam logic [7:0] EXT_TAG_OFS   = 8'h40;
  localparam logic [7:0] EXT_MAJOR_OFS = 8'h43;
  localparam logic [7:0] EXT_MINOR_OFS = 8'h44;
  localparam logic [7:0] EXT_UNLK_OFS  = 8'h45;
  localparam logic [7:0] EXT_SUSP_OFS  = 8'h46;
  localparam logic [7:0] EXT_PROT_OFS  = 8'h49;
  localparam logic [7:0] EXT_BOOT_OFS  = 8'h4f;

  // ***************
  // status bits read from the flash
  // ***************
  localparam int TIMEOUT_STATUS_BIT      = 5;
  localparam int BUFFER_ABORT_STATUS_BIT = 1;

  // ***************
  // user operations
  // ***************
  typedef enum logic [2:0] {
    OP_READ        = 3'b000,
    OP_WRITE_RAW   = 3'b001,
    OP_RESET       = 3'b010,
    OP_AUTOSELECT  = 3'b011,
    OP_ID_READ     = 3'b100,
    OP_QUERY       = 3'b101,
    OP_ABORT_RESET = 3'b110
  } fhc_op_type;

  typedef struct packed {
    fhc_op_type              op;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       data;
  } fhc_req_type;

  typedef struct packed {
    logic                    ceN;
    logic                    weN;
    logic                    oeN;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       dqOut;
    logic                    dqOe;
  } fhc_pins_type;

  // word offset to byte offset when the bus is byte wide
  function automatic logic [ADDR_W-1:0] bus_ofs(input logic byteMode,
                                                input logic [ADDR_W-1:0] wordOfs);
    bus_ofs = byteMode ? {wordOfs[ADDR_W-2:0], 1'b0} : wordOfs;
  endfunction : bus_ofs

endpackage : fhc_pkg

// *** core/fhc_bus_cycle.sv ***
// one asynchronous bus cycle (write or read) on the flash pins
// assumes a single clock; pin inputs are synchronous to core_clk
`timescale 1ns/10ps
module fhc_bus_cycle
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic                       clkEn,
  // request
  input  wire logic                       start,
  input  wire logic                       isWrite,
  input  wire logic [fhc_pkg::ADDR_W-1:0] addr,
  input  wire logic [fhc_pkg::DATA_W-1:0] wdata,
  output logic                            done,
  output logic [fhc_pkg::DATA_W-1:0]      rdata,
  // flash pins
  input  wire logic [fhc_pkg::DATA_W-1:0] dqIn,
  output fhc_pkg::fhc_pins_type           pins
);
  import fhc_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_SETUP = 2'b01,
    C_STRB  = 2'b10,
    C_HOLD  = 2'b11
  } fhc_cyc_type;

  fhc_cyc_type  state, next_state;
  logic [7:0]   cnt, next_cnt;
  logic         wr, next_wr;
  fhc_pins_type next_pins;
  logic         next_done;
  logic [DATA_W-1:0] next_rdata;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_wr    = wr;
    next_pins  = pins;
    next_done  = 1'b0;
    next_rdata = rdata;
    unique case (state)
      C_IDLE:
        if (start)
        begin
          next_wr         = isWrite;
          next_pins.addr  = addr;
          next_pins.dqOut = wdata;
          next_pins.dqOe  = ~isWrite;
          next_pins.ceN   = 1'b0;
          next_cnt        = SETUP_CYC;
          next_state      = C_SETUP;
        end
      C_SETUP:
        if (cnt <= 8'h01)
        begin
          // address caught by the later falling strobe (weN after ceN)
          next_pins.weN = ~wr;
          next_pins.oeN = wr;
          next_cnt      = wr ? STROBE_CYC : READ_CYC;
          next_state    = C_STRB;
        end
        else
          next_cnt = cnt - 8'h01;
      C_STRB:
        if (cnt <= 8'h01)
        begin
          // data caught by the first rising strobe, held on dq
          next_pins.weN = 1'b1;
          next_pins.oeN = 1'b1;
          if (!wr)
            next_rdata = dqIn;
          next_cnt   = HOLD_CYC;
          next_state = C_HOLD;
        end
        else
          next_cnt = cnt - 8'h01;
      C_HOLD:
        if (cnt <= 8'h01)
        begin
          next_pins.ceN  = 1'b1;
          next_pins.dqOe = 1'b1;
          next_done      = 1'b1;
          next_state     = C_IDLE;
        end
        else
          next_cnt = cnt - 8'h01;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= C_IDLE;
      cnt   <= 8'h00;
      wr    <= 1'b0;
      done  <= 1'b0;
      rdata <= 16'h0000;
      pins  <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b1};
    end
    else if (clkEn)
    begin
      state <= next_state;
      cnt   <= next_cnt;
      wr    <= next_wr;
      done  <= next_done;
      rdata <= next_rdata;
      pins  <= next_pins;
    end
  end

endmodule : fhc_bus_cycle

// *** bench/fhc_host_monitor.sv ***
// checker on the flash command host ports: handshake and pin timing
// assumes fhc_pkg compiled first; bound onto every fhc_host
`timescale 1ns/10ps
module fhc_host_monitor
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             clkEn,
  // user side
  input wire logic             reqValid,
  input fhc_pkg::fhc_req_type  req,
  input wire logic             reqReady,
  input wire logic             rspValid,
  input wire logic             timeoutSeen,
  input wire logic             abortSeen,
  input wire logic             inAutoselect,
  // flash pins
  input fhc_pkg::fhc_pins_type flashPins
);
  import fhc_pkg::*;
  // ***************
  // properties
  // ***************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire take  = reqValid && reqReady && clkEn;
  wire rstOp = take && (req.op == OP_RESET || req.op == OP_ABORT_RESET);

  take_busy_a: assert property (take |=> !reqReady)
    else $error("ready still high after take");
  resp_bound_a: assert property (take |-> ##[1:60] rspValid)
    else $error("no response in time");
  write_select_a: assert property (
    !flashPins.weN |-> !flashPins.ceN && !flashPins.dqOe && flashPins.oeN)
    else $error("write strobe without select or drive");
  write_hold_a: assert property (
    !flashPins.weN && !$past(flashPins.weN) |-> $stable(flashPins.addr) && $stable(flashPins.dqOut))
    else $error("address or data moved under write strobe");
  write_len_a: assert property (
    $fell(flashPins.weN) |-> (!flashPins.weN)[*6] ##1 flashPins.weN)
    else $error("write strobe length wrong");
  read_len_a: assert property (
    $fell(flashPins.oeN) |-> (!flashPins.oeN)[*8] ##1 !flashPins.oeN ##1 flashPins.oeN)
    else $error("read strobe length wrong");
  read_release_a: assert property (!flashPins.oeN |-> flashPins.dqOe && flashPins.weN)
    else $error("host drives data during read");
  flags_clear_a: assert property (
    rstOp |-> ##[1:60] (rspValid && !timeoutSeen && !abortSeen && !inAutoselect))
    else $error("flags not cleared by reset");
endmodule : fhc_host_monitor

bind fhc_host fhc_host_monitor u_mon (.core_clk, .rstn, .clkEn, .reqValid, .req, .reqReady,
  .rspValid, .timeoutSeen, .abortSeen, .inAutoselect, .flashPins);

// *** bench/fhc_flash_model.sv ***
// behavioural nor flash: array read, autoselect, query table, reset
// assumes pins registered on core_clk; no power-up reset pin
`timescale 1ns/10ps
module fhc_flash_model
#(
  // arbitrary id codes and status
  parameter logic [15:0] MFR_CODE  = 16'h0011,
  parameter logic [15:0] DEV1_CODE = 16'h0021,
  parameter logic [15:0] DEV2_CODE = 16'h0032,
  parameter logic [15:0] DEV3_CODE = 16'h0043,
  parameter logic [15:0] LOCK_VAL  = 16'h0080
)
(
  // clock and mode
  input wire logic             core_clk,
  input wire logic             byteMode,
  input wire logic [15:0]      inj,
  // pins
  input fhc_pkg::fhc_pins_type pins,
  output logic [15:0]          dqIn
);
  import fhc_pkg::*;
  // ***************
  // command decode and read mux
  // ***************
  typedef enum logic [1:0] {ARR, AUTO, QRY} fhc_mode_type;
  fhc_mode_type mode = ARR;
  logic [1:0]  step = 2'h0;
  logic        wrP = 1'b0;
  logic        susp = 1'b0;
  logic [6:0]  sSec = 7'h00;
  logic [21:0] la = 22'h0;
  logic [21:0] wa, ra;
  logic [15:0] v;
  logic [7:0]  cmd;
  wire wr = !pins.ceN && !pins.weN;
  initial dqIn = 16'h0000;
  function automatic logic [21:0] wad(input logic bm, input logic [21:0] a);
    return bm ? {1'b0, a[21:1]} : a;
  endfunction : wad
  assign wa  = wad(byteMode, la);
  assign ra  = wad(byteMode, pins.addr);
  assign cmd = pins.dqOut[7:0];
  always_comb
  begin
    v = 16'h0000;
    if (mode == ARR)
      // suspended sector reads nothing useful; every other sector reads array
      v = (susp && pins.addr[21:15] == sSec) ? 16'h0000
                                             : pins.addr[15:0] ^ 16'hc385 ^ inj;
    else if (mode == AUTO)
      case (ra[7:0])
        8'h00: v = MFR_CODE;
        8'h01: v = DEV1_CODE;
        8'h0e: v = DEV2_CODE;
        8'h0f: v = DEV3_CODE;
        8'h03: v = LOCK_VAL;
        8'h02: v = {15'h0, ra[15]};
        default: v = 16'h0000;
      endcase
    else
      case (ra[7:0])
        8'h40: v = 16'h0050;
        8'h41: v = 16'h0052;
        8'h42: v = 16'h0049;
        8'h43: v = 16'h0031;
        8'h44: v = 16'h0033;
        8'h45: v = 16'h0010;
        8'h46: v = 16'h0002;
        8'h49: v = 16'h0008;
        8'h4f: v = 16'h0002;
        default: v = 16'h0000;
      endcase
  end
  always @(posedge core_clk)
  begin
    wrP  <= wr;
    dqIn <= (!pins.ceN && !pins.oeN) ? v : ~dqIn;
    if (wr && !wrP)
      la <= pins.addr;
    if (wrP && !wr)
    begin
      if (cmd == 8'hf0)
      begin
        mode <= ARR;
        step <= 2'h0;
      end
      else if (cmd == 8'hb0)
      begin
        susp <= 1'b1;
        sSec <= la[21:15];
      end
      else if (cmd == 8'h30)
        susp <= 1'b0;
      else if (wa[10:0] == 11'h055 && cmd == 8'h98)
        mode <= QRY;
      else if (step == 2'h0 && wa[10:0] == 11'h555 && cmd == 8'haa)
        step <= 2'h1;
      else if (step == 2'h1 && wa[10:0] == 11'h2aa && cmd == 8'h55)
        step <= 2'h2;
      else if (step == 2'h2 && wa[10:0] == 11'h555 && cmd == 8'h90)
        mode <= AUTO;
      else
        step <= 2'h0;
    end
  end
endmodule : fhc_flash_model

// *** bench/fhc_host_tb.sv ***
// self-checking bench for the flash command host
// assumes fhc_pkg, fhc_host, the flash model and the bound checker
`timescale 1ns/10ps
module fhc_host_tb;
  import fhc_pkg::*;
  // ***************
  // design, flash and helpers
  // ***************
  logic         core_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         clkEn = 1'b1;
  logic         reqValid = 1'b0;
  logic         byteMode = 1'b0;
  fhc_req_type  req = '0;
  logic [15:0]  inj = 16'h0000;
  logic         reqReady, rspValid, timeoutSeen, abortSeen, inAutoselect;
  logic [15:0]  rspData, dqIn;
  fhc_pins_type flashPins;
  int           errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  localparam logic [7:0]  QOFS [9] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
                                       8'h49, 8'h4f};
  localparam logic [15:0] QVAL [9] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
                                       16'h0010, 16'h0002, 16'h0008, 16'h0002};
  initial forever #5 core_clk = ~core_clk;
  fhc_host DUT (.core_clk, .rstn, .clkEn, .reqValid, .req, .byteMode, .reqReady, .rspValid,
    .rspData, .timeoutSeen, .abortSeen, .inAutoselect, .dqIn, .flashPins);
  fhc_flash_model flash (.core_clk, .byteMode, .inj, .pins(flashPins), .dqIn);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // one request; frz holds clkEn low first
  task automatic op(input fhc_op_type o, input logic [21:0] a,
                    input logic [15:0] d = 16'h0000, input bit frz = 1'b0);
    int n;
    n = 0;
    req = '{o, a, d};
    reqValid = 1'b1;
    if (frz)
    begin
      clkEn = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      chk({14'h0, flashPins.ceN, reqReady}, 16'h0003);
      clkEn = 1'b1;
    end
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({15'h0, rspValid}, 16'h0001);
  endtask : op

  task automatic rd(input fhc_op_type o, input logic [21:0] a, input logic [15:0] e,
                    input bit frz = 1'b0);
    op(o, a, 16'h0000, frz);
    chk(rspData, e);
  endtask : rd

  task automatic t_array;
    rd(OP_READ, 22'h012345, 16'h2345 ^ 16'hc385, 1'b1);
  endtask : t_array

  task automatic t_autosel;
    op(OP_AUTOSELECT, 22'h0);
    chk({15'h0, inAutoselect}, 16'h0001);
    rd(OP_ID_READ, 22'h000000, flash.MFR_CODE);
    rd(OP_ID_READ, 22'h000001, flash.DEV1_CODE);
    rd(OP_ID_READ, 22'h00000e, flash.DEV2_CODE);
    rd(OP_ID_READ, 22'h00000f, flash.DEV3_CODE);
    rd(OP_ID_READ, 22'h000003, flash.LOCK_VAL);
    rd(OP_ID_READ, 22'h008002, 16'h0001);
    rd(OP_ID_READ, 22'h000002, 16'h0000);
    rd(OP_ID_READ, 22'h000001, flash.DEV1_CODE);
    op(OP_RESET, 22'h0);
    chk({15'h0, inAutoselect}, 16'h0000);
    rd(OP_READ, 22'h000001, 16'h0001 ^ 16'hc385);
  endtask : t_autosel

  task automatic t_query;
    op(OP_QUERY, 22'h0);
    for (int i = 0; i < 9; i++)
      rd(OP_ID_READ, {14'h0, QOFS[i]}, QVAL[i]);
    op(OP_RESET, 22'h0);
    byteMode = 1'b1;
    op(OP_AUTOSELECT, 22'h0);
    rd(OP_ID_READ, 22'h00000e, flash.DEV2_CODE);
    op(OP_RESET, 22'h0);
    op(OP_QUERY, 22'h0);
    rd(OP_ID_READ, 22'h000043, 16'h0031);
    op(OP_RESET, 22'h0);
    byteMode = 1'b0;
  endtask : t_query

  task automatic t_status;
    inj = 16'h0020;
    rd(OP_READ, 22'h000010, 16'h0010 ^ 16'hc385 ^ 16'h0020);
    chk({15'h0, timeoutSeen}, 16'h0001);
    inj = 16'h0000;
    op(OP_RESET, 22'h0);
    chk({15'h0, timeoutSeen}, 16'h0000);
    inj = 16'h0002;
    rd(OP_READ, 22'h000020, 16'h0020 ^ 16'hc385 ^ 16'h0002);
    chk({15'h0, abortSeen}, 16'h0001);
    inj = 16'h0000;
    op(OP_ABORT_RESET, 22'h0);
    chk({15'h0, abortSeen}, 16'h0000);
  endtask : t_status

  task automatic t_partial;
    op(OP_WRITE_RAW, 22'h000555, 16'h00aa);
    op(OP_WRITE_RAW, 22'h0002aa, 16'h0055);
    op(OP_RESET, 22'h0);
    op(OP_WRITE_RAW, 22'h000555, 16'h0090);
    rd(OP_READ, 22'h000000, 16'hc385);
    // suspend sector 0, enter and leave autoselect, read another sector
    op(OP_WRITE_RAW, 22'h000000, 16'h00b0);
    op(OP_AUTOSELECT, 22'h0);
    op(OP_RESET, 22'h0);
    rd(OP_READ, 22'h008040, 16'h8040 ^ 16'hc385);
    op(OP_WRITE_RAW, 22'h000000, 16'h0030);
  endtask : t_partial

  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_array;
    t_autosel;
    t_query;
    t_status;
    t_partial;
    tally_and_finish;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      tally_and_finish;
    end
  end
endmodule : fhc_host_tb
